// File: rtl/otp_bank_pick.sv
// Purpose: Combines one bank into the running field selection
// Assumes: Called once per bank in ascending order
// Notes:   Pure combinational; later valid banks override earlier ones
module otp_bank_pick (
    // Bank under inspection
    input  wire logic [otp_pkg::BANK_BITS-1:0]  bank_word,
    // Running selection
    input  wire logic [otp_pkg::FIXED_BITS-1:0] cur_fields,
    input  wire logic [otp_pkg::NUM_FIELDS-1:0] cur_valid,
    // Updated selection
    output logic      [otp_pkg::FIXED_BITS-1:0] new_fields,
    output logic      [otp_pkg::NUM_FIELDS-1:0] new_valid
);
    localparam int LSBS [otp_pkg::NUM_FIELDS] = '{otp_pkg::HWID_LSB,
        otp_pkg::ADC_LSB, otp_pkg::FREQ_LSB, otp_pkg::AMP_LSB,
        otp_pkg::PHA_LSB};
    localparam int WS [otp_pkg::NUM_FIELDS] = '{otp_pkg::HWID_W,
        otp_pkg::ADC_W, otp_pkg::FREQ_W, otp_pkg::AMP_W, otp_pkg::PHA_W};

    wire logic bank_live;
    // Retired bank contributes nothing
    assign bank_live = ~bank_word[otp_pkg::INVAL_BIT];

    assign new_fields[otp_pkg::FIXED_BITS-1:otp_pkg::VALID_LSB] =
        cur_fields[otp_pkg::FIXED_BITS-1:otp_pkg::VALID_LSB];

    genvar g;
    generate
        for (g = 0; g < otp_pkg::NUM_FIELDS; g++)
        begin : g_fld
            wire logic take;
            // Flag 1 means usable, 0 means ignore
            assign take = bank_live &
                bank_word[otp_pkg::VALID_LSB+g];
            assign new_fields[LSBS[g]+WS[g]-1:LSBS[g]] = take ?
                bank_word[LSBS[g]+WS[g]-1:LSBS[g]] :
                cur_fields[LSBS[g]+WS[g]-1:LSBS[g]];
            assign new_valid[g] = take | cur_valid[g];
        end
    endgenerate
endmodule : otp_bank_pick

// File: rtl/otp_bank_selector.sv
// Purpose: Presents a six bank fuse store and selects usable fields
// Assumes: Fuse array contents arrive as a flat input vector
// Notes:   Register reads return data the cycle after the read strobe

// Contract
// - Store holds 768 bits as six independent 128-bit banks, same layout.
// - Fuse contents become readable once reset has been left; register reads return zero until the six bank scan finishes.
// - Lowest 80 bits of each bank are fixed fields; upper 48 general.
// - Every bank programs independently, allowing updates in fresh banks.
// - Each field has its own validity flag in the same bank.
// - Flag 0 means field ignored; flag 1 means field usable.
// - Delivered parts carry trim fields, and any hardware id, in bank one.
// - Sleep clock is internal ring or external input, chosen by software.
// - Internal sleep clock widens early wake margin to 1% of sleep time.
module otp_bank_selector #(
    parameter int NUM_BANKS  = otp_pkg::NUM_BANKS,
    parameter int BANK_BITS  = otp_pkg::BANK_BITS
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    // Fuse array
    input  wire logic [NUM_BANKS*BANK_BITS-1:0] fuse_bits,
    // Register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [31:0]                   reg_rdata,
    // Sleep clocks
    input  wire logic                          ring_clk_in,
    input  wire logic                          ext_clk_in,
    output logic                               sleep_clk_out,
    output logic                               ring_sel_out,
    // Selected fields
    output logic [otp_pkg::HWID_W-1:0]         station_hw_identifier,
    output logic [otp_pkg::AMP_W-1:0]          amplitude_trim_field,
    output logic [otp_pkg::PHA_W-1:0]          phase_trim_field,
    output logic                               amplitude_trim_valid,
    output logic                               phase_trim_valid,
    output logic                               fuse_ready
);
    otp_pkg::scan_state_t state_r;
    otp_pkg::scan_state_t state_nxt;
    logic [2:0]                        bank_idx_r;
    logic [otp_pkg::FIXED_BITS-1:0]    fields_r;
    logic [otp_pkg::NUM_FIELDS-1:0]    valid_r;
    logic                              clksel_r;
    logic [31:0]                       sleep_r;
    logic [31:0]                       rdata_r;
    logic                              sleep_clk_r;
    logic                              ring_sel_r;
    logic                              ready_r;

    // One bank per cycle keeps the combiner small
    wire logic [BANK_BITS-1:0] bank_word;
    assign bank_word = fuse_bits[bank_idx_r*BANK_BITS +: BANK_BITS];

    wire logic [otp_pkg::FIXED_BITS-1:0] pick_fields;
    wire logic [otp_pkg::NUM_FIELDS-1:0] pick_valid;

    otp_bank_pick u_pick (
        .bank_word  (bank_word),
        .cur_fields (fields_r),
        .cur_valid  (valid_r),
        .new_fields (pick_fields),
        .new_valid  (pick_valid)
    );

    wire logic last_bank;
    assign last_bank = (bank_idx_r == 3'(NUM_BANKS-1));

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            otp_pkg::SC_IDLE: state_nxt = otp_pkg::SC_SCAN;
            otp_pkg::SC_SCAN: if (last_bank) state_nxt = otp_pkg::SC_DONE;
            otp_pkg::SC_DONE: state_nxt = otp_pkg::SC_DONE;
        endcase
    end

    // Scan starts at reset release, ascending order
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r    <= otp_pkg::SC_IDLE;
            bank_idx_r <= 3'h0;
            fields_r   <= '0;
            valid_r    <= '0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            if (state_r == otp_pkg::SC_SCAN)
            begin
                fields_r <= pick_fields;
                valid_r  <= pick_valid;
                if (!last_bank)
                    bank_idx_r <= bank_idx_r + 3'h1;
            end
        end
    end

    // Register decode
    wire logic sel_raw;
    wire logic [2:0] raw_bank;
    wire logic [1:0] raw_word;
    wire logic [7:0] raw_off;
    assign raw_off  = reg_addr - otp_pkg::REG_RAW_BASE;
    assign sel_raw  = (reg_addr >= otp_pkg::REG_RAW_BASE) &&
                      (raw_off < 8'(NUM_BANKS*4));
    assign raw_bank = raw_off[4:2];
    assign raw_word = raw_off[1:0];

    // Ring clock is only 10000 ppm, so margin is 1 percent
    wire logic [31:0] margin;
    assign margin = clksel_r ?
        32'(sleep_r / 32'(otp_pkg::MARGIN_DIV_INT)) : 32'h0;

    wire logic done;
    assign done = (state_r == otp_pkg::SC_DONE);

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        // Nothing visible until the scan finishes after reset
        if (!done)
            rd_mux = 32'h0;
        else if (sel_raw)
            rd_mux = fuse_bits[(32'(raw_bank)*BANK_BITS
                     + 32'(raw_word)*32) +: 32];
        else
            unique case (reg_addr)
                otp_pkg::REG_HWID_LO: rd_mux = fields_r[31:0];
                otp_pkg::REG_HWID_HI: rd_mux = {16'h0, fields_r[47:32]};
                otp_pkg::REG_CALIB:   rd_mux = {8'h0,
                    fields_r[otp_pkg::VALID_LSB-1:otp_pkg::ADC_LSB]};
                otp_pkg::REG_STATUS:  rd_mux = {26'h0, valid_r, done};
                otp_pkg::REG_CLKSEL:  rd_mux = {31'h0, clksel_r};
                otp_pkg::REG_SLEEP:   rd_mux = sleep_r;
                otp_pkg::REG_MARGIN:  rd_mux = margin;
                default:              rd_mux = 32'h0;
            endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clksel_r <= otp_pkg::CLKSEL_RST;
            sleep_r  <= otp_pkg::SLEEP_RST;
            rdata_r  <= 32'h0;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == otp_pkg::REG_CLKSEL)
                clksel_r <= reg_wdata[0];
            if (reg_wr && reg_addr == otp_pkg::REG_SLEEP)
                sleep_r <= reg_wdata;
            rdata_r <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // Sleep clock retimed here, so it is a sampled copy at clk_sys rate
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sleep_clk_r <= 1'b0;
            ring_sel_r  <= 1'b0;
            ready_r     <= 1'b0;
        end
        else if (clk_en)
        begin
            sleep_clk_r <= clksel_r ? ring_clk_in : ext_clk_in;
            ring_sel_r  <= clksel_r;
            ready_r     <= done;
        end
    end

    assign reg_rdata             = rdata_r;
    assign sleep_clk_out         = sleep_clk_r;
    assign ring_sel_out          = ring_sel_r;
    assign fuse_ready            = ready_r;
    assign station_hw_identifier = fields_r[otp_pkg::HWID_W-1:0];
    assign amplitude_trim_field  =
        fields_r[otp_pkg::AMP_LSB+otp_pkg::AMP_W-1:otp_pkg::AMP_LSB];
    assign phase_trim_field      =
        fields_r[otp_pkg::PHA_LSB+otp_pkg::PHA_W-1:otp_pkg::PHA_LSB];
    assign amplitude_trim_valid  = valid_r[otp_pkg::F_AMP];
    assign phase_trim_valid      = valid_r[otp_pkg::F_PHA];
endmodule : otp_bank_selector

// File: rtl/otp_pkg.sv
// Purpose: Shared constants for the fuse bank selector
// Assumes: Field layout within the fixed 80 bits is a working choice
// Notes:   Offsets are word indices on the plain register port
package otp_pkg;
    localparam int NUM_BANKS   = 6;
    localparam int BANK_BITS   = 128;
    localparam int TOTAL_BITS  = 768;
    localparam int FIXED_BITS  = 80;
    localparam int GP_BITS     = 48;
    localparam int NUM_FIELDS  = 5;
    // Field positions inside one bank
    localparam int HWID_LSB    = 0;
    localparam int HWID_W      = 48;
    localparam int ADC_LSB     = 48;
    localparam int ADC_W       = 8;
    localparam int FREQ_LSB    = 56;
    localparam int FREQ_W      = 8;
    localparam int AMP_LSB     = 64;
    localparam int AMP_W       = 4;
    localparam int PHA_LSB     = 68;
    localparam int PHA_W       = 4;
    localparam int VALID_LSB   = 72;
    localparam int INVAL_BIT   = 79;
    localparam int GP_LSB      = 80;
    // Field index order in the validity vector
    localparam int F_HWID      = 0;
    localparam int F_ADC       = 1;
    localparam int F_FREQ      = 2;
    localparam int F_AMP       = 3;
    localparam int F_PHA       = 4;
    // Register word indices
    localparam logic [7:0] REG_HWID_LO  = 8'h00;
    localparam logic [7:0] REG_HWID_HI  = 8'h01;
    localparam logic [7:0] REG_CALIB    = 8'h02;
    localparam logic [7:0] REG_STATUS   = 8'h03;
    localparam logic [7:0] REG_CLKSEL   = 8'h04;
    localparam logic [7:0] REG_SLEEP    = 8'h05;
    localparam logic [7:0] REG_MARGIN   = 8'h06;
    localparam logic [7:0] REG_RAW_BASE = 8'h10;
    // Reset values
    localparam logic       CLKSEL_RST   = 1'b0;
    localparam logic [31:0] SLEEP_RST   = 32'h0000_0000;
    // Wider margin divisor for the ring oscillator (1 percent)
    localparam int MARGIN_DIV_INT = 100;
    typedef enum logic [1:0] {SC_IDLE, SC_SCAN, SC_DONE} scan_state_t;
endpackage : otp_pkg

// File: verification/otp_bank_selector_monitor.sv
// Purpose: Port checks for the fuse bank selector
// Assumes: One clock, sync active high reset
// Notes:   Bound to every selector instance
module otp_bank_selector_monitor (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // Register port
    input wire logic [7:0]                reg_addr,
    input wire logic [31:0]               reg_wdata,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [31:0]               reg_rdata,
    // Status
    input wire logic                      ring_sel_out,
    input wire logic                      ring_clk_in,
    input wire logic                      ext_clk_in,
    input wire logic                      sleep_clk_out,
    input wire logic [otp_pkg::AMP_W-1:0] amplitude_trim_field,
    input wire logic                      amplitude_trim_valid,
    input wire logic                      fuse_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire sel_wr = reg_wr && reg_addr == 8'h04;
    property p_rdy;
        $fell(rst) |-> !fuse_ready [*6] ##[1:6] fuse_ready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("scan time");
    property p_nrd; !fuse_ready |-> reg_rdata == 32'h0; endproperty
    a_nrd: assert property (p_nrd) else $error("early read");
    property p_amp;
        !amplitude_trim_valid |-> amplitude_trim_field == 4'h0;
    endproperty
    a_amp: assert property (p_amp) else $error("amp not void");
    // Select output trails the write by two edges
    property p_sel;
        $past(sel_wr, 2) && !$past(rst) && !$past(rst, 2) |->
            ring_sel_out == $past(reg_wdata[0], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("select write");
    property p_hold;
        !$past(sel_wr, 2) && !$past(rst) && !$past(rst, 2) |->
            $stable(ring_sel_out);
    endproperty
    a_hold: assert property (p_hold) else $error("select moved");
    // One cycle later the select output shows what the read used
    property p_mgn;
        $past(reg_rd && reg_addr == 8'h06) && !ring_sel_out |->
            reg_rdata == 0;
    endproperty
    a_mgn: assert property (p_mgn) else $error("margin nonzero");
    property p_sts;
        $past(reg_rd && reg_addr == 8'h03) && fuse_ready |-> reg_rdata[0]
        && reg_rdata[4] == amplitude_trim_valid && reg_rdata[31:6] == 26'h0;
    endproperty
    a_sts: assert property (p_sts) else $error("status word");
    property p_raw; $past(reg_rd && reg_addr == 8'h28) |-> reg_rdata == 0;
    endproperty
    a_raw: assert property (p_raw) else $error("bank six read");
    property p_sck;
        !$past(rst) |-> sleep_clk_out ==
            (ring_sel_out ? $past(ring_clk_in) : $past(ext_clk_in));
    endproperty
    a_sck: assert property (p_sck) else $error("sleep clock");
    c_rdy: cover property ($rose(fuse_ready));
    c_ring: cover property (ring_sel_out && reg_rd && reg_addr == 8'h06);
    c_trim: cover property (amplitude_trim_valid && fuse_ready);
endmodule : otp_bank_selector_monitor
bind otp_bank_selector otp_bank_selector_monitor u_mon (.*);

// File: verification/otp_fuse_model.sv
// Purpose: Fuse store seen by the selector
// Assumes: Burning only sets bits, never clears them
// Notes:   Burn only while the selector is held in reset
module otp_fuse_model (
    // Clock
    input wire logic          clk_sys,
    // Burn port
    input wire logic          burn,
    input wire logic [2:0]    burn_bank,
    input wire logic [127:0]  burn_bits,
    // Store
    output logic      [767:0] fuse_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [127:0] bank_r [6] = '{default: 128'h0};
    // A burn touches one bank only
    always_ff @(posedge clk_sys)
    begin
        if (burn)
            bank_r[burn_bank] <= bank_r[burn_bank] | burn_bits;
    end
    always_comb
    begin
        for (int b = 0; b < 6; b++)
            fuse_bits[b*128 +: 128] = bank_r[b];
    end
endmodule : otp_fuse_model

// File: verification/tb_otp_bank_selector.sv
// Purpose: Self checking run of the fuse bank selector
// Assumes: Fuses are burned only during reset
// Notes:   Expectations come from a mirror of burned banks
module tb_otp_bank_selector;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic         ring_clk_in = 1'b0, ext_clk_in = 1'b0, burn = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0, reg_rdata, d, s;
    logic [2:0]   burn_bank = 3'h0;
    logic [127:0] burn_bits = 128'h0, c, w [5];
    logic [127:0] exp_b [6] = '{default: 128'h0};
    logic [767:0] fuse_bits;
    logic [47:0]  station_hw_identifier;
    logic [3:0]   amplitude_trim_field, phase_trim_field;
    logic         amplitude_trim_valid, phase_trim_valid, fuse_ready;
    logic         sleep_clk_out, ring_sel_out;
    logic [1:0]   ck_q = 2'h0;
    int           seed = 58, n_mismatch = 0, num_checks = 0;
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) {ring_clk_in, ext_clk_in} <= 2'($random(seed));
    // Sleep clock levels as the design took them at the last edge
    always @(posedge clk_sys) ck_q <= {ring_clk_in, ext_clk_in};
    otp_bank_selector u_dut (.clk_en(1'b1), .*);
    otp_fuse_model u_fuse (.*);
    task automatic chk(input string nm, input logic [127:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %0s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input int v);
        @(posedge clk_sys);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : bus
    task automatic fire(input int b, input logic [127:0] v);
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        burn      <= 1'b1;
        burn_bank <= 3'(b);
        burn_bits <= v;
        @(posedge clk_sys);
        burn     <= 1'b0;
        exp_b[b] = exp_b[b] | v;
    endtask : fire
    function automatic logic [127:0] mk(input logic [4:0] fl);
        logic [127:0] r;
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        return {r[127:80], 3'h0, fl, r[71:0]};
    endfunction : mk
    // Later live banks override, so the last hit wins
    function automatic logic [127:0] win(input int f);
        win = 128'h0;
        for (int b = 0; b < 6; b++)
            if (!exp_b[b][79] && exp_b[b][72+f])
                win = exp_b[b];
    endfunction : win
    task automatic run(input string nm);
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, 8'h03, 0);
        chk("early", d, 0);
        for (int i = 0; i < 40 && fuse_ready !== 1'b1; i++)
            @(posedge clk_sys);
        #1 chk("ready", fuse_ready, 1);
        for (int f = 0; f < 5; f++)
            w[f] = win(f);
        chk("hwid", station_hw_identifier, w[0][47:0]);
        chk("amp", {amplitude_trim_valid, amplitude_trim_field},
            {w[3][75], w[3][67:64]});
        chk("pha", {phase_trim_valid, phase_trim_field},
            {w[4][76], w[4][71:68]});
        bus(1'b0, 8'h03, 0);
        chk("status", d,
            {w[4][76], w[3][75], w[2][74], w[1][73], w[0][72], 1'b1});
        bus(1'b0, 8'h00, 0);
        chk("hwid lo", d, w[0][31:0]);
        bus(1'b0, 8'h01, 0);
        chk("hwid hi", d, w[0][47:32]);
        bus(1'b0, 8'h02, 0);
        chk("calib", d, {w[4][71:68], w[3][67:64], w[2][63:56],
            w[1][55:48]});
        for (int i = 0; i < 24; i++)
        begin
            bus(1'b0, 8'h10 + 8'(i), 0);
            chk("raw", d, exp_b[i/4][i%4*32 +: 32]);
        end
        $display("test %0s done", nm);
    endtask : run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    initial
    begin
        run("blank");
        fire(0, 128'h1 << 79);
        fire(1, mk(5'h19));
        run("delivered");
        fire(1, 128'h1 << 79);
        c = mk(5'h00);
        c[71:48] = exp_b[1][71:48];
        fire(2, c);
        fire(2, {48'h0, 8'h1f, 72'h0});
        run("update");
        for (int b = 3; b < 6; b++)
            fire(b, mk(5'($random(seed))) | (128'(b & 1) << 79));
        run("random");
        s = $random(seed);
        bus(1'b1, 8'h04, 1);
        bus(1'b1, 8'h05, s);
        chk("ring", ring_sel_out, 1);
        chk("sleep ring", sleep_clk_out, ck_q[1]);
        bus(1'b0, 8'h04, 0);
        chk("clksel", d, 1);
        bus(1'b0, 8'h05, 0);
        chk("sleep reg", d, s);
        bus(1'b0, 8'h06, 0);
        chk("margin", d, s / 100);
        bus(1'b1, 8'h04, 0);
        bus(1'b0, 8'h06, 0);
        chk("margin off", d, 0);
        chk("sleep ext", sleep_clk_out, ck_q[0]);
        bus(1'b0, 8'h28, 0);
        chk("bank six", d, 0);
        $display("test clock done");
        complete_run;
    end
    // Four scans and about 125 bus cycles fit well inside
    initial
    begin
        #2000000;
        n_mismatch++;
        complete_run;
    end
endmodule : tb_otp_bank_selector
